// ===== rtl/dhh_map.svh
/*
  Register indices, field positions, reset values and timing counts for
  the holdover history and phase control block.
  Assumes a 20 MHz system clock and a word-per-register bus mapping.
*/
`ifndef DHH_MAP_SVH
`define DHH_MAP_SVH

// Register indices (byte address is four times the index)
`define DHH_IDX_FRTW0 10'h300
`define DHH_IDX_FRTW1 10'h301
`define DHH_IDX_FRTW2 10'h302
`define DHH_IDX_FRTW3 10'h303
`define DHH_IDX_STEP_LO 10'h310
`define DHH_IDX_STEP_HI 10'h311
`define DHH_IDX_SLEW_LO 10'h312
`define DHH_IDX_SLEW_HI 10'h313
`define DHH_IDX_TIMER_LO 10'h314
`define DHH_IDX_TIMER_HI 10'h315
`define DHH_IDX_MODE 10'h316
`define DHH_IDX_IRQ_STAT 10'h380
`define DHH_IDX_IRQ_EN 10'h381
`define DHH_IDX_IRQ_CLR 10'h382
`define DHH_IDX_STATUS 10'h383

// Reset values
`define DHH_RST_STEP 16'h0000
`define DHH_RST_SLEW 16'h0000
`define DHH_RST_TIMER 16'h000a
`define DHH_RST_MODE 5'h00
`define DHH_RST_FRTW 30'h1b641511

// Field positions and masks
`define DHH_MODE_FALLBACK 4
`define DHH_MODE_PERSIST 3
`define DHH_FRTW3_MASK 8'h3f
`define DHH_IRQ_SLEW_ON 0
`define DHH_IRQ_SLEW_OFF 1
`define DHH_IRQ_HIST 4
`define DHH_IRQ_MASK 8'h13

// Bus responses
`define DHH_RESP_OKAY 2'h0
`define DHH_RESP_SLVERR 2'h2

// Timing: clock period, one microsecond and one millisecond
`define DHH_CLK_PERIOD_NS 50
`define DHH_US_PERIOD_NS 1000
`define DHH_MS_PERIOD_US 1000
`define DHH_US_CYC (`DHH_US_PERIOD_NS / `DHH_CLK_PERIOD_NS)
`define DHH_MS_CYC (`DHH_MS_PERIOD_US * `DHH_US_CYC)

`endif

// ===== rtl/dhh_pkg.sv
/*
  Types shared by the holdover history and phase control block.
  Assumes the map header supplies all numeric constants.
*/
package dhh_pkg;

  // Signals coming from the loop core
  typedef struct packed {
    logic [29:0] tw;
    logic locked;
    logic ref_switch;
    logic holdover;
    logic step_up;
    logic step_dn;
  } dhh_dpll_in_t;

  // Values handed back to the loop core
  typedef struct packed {
    logic [29:0] holdover_tw;
    logic [31:0] phase_offset;
    logic hist_valid;
  } dhh_dpll_out_t;

  // Slew limiter states
  typedef enum logic [0:0] {
    SLW_TRACK,
    SLW_LIMIT
  } dhh_slew_st_t;

endpackage

// ===== rtl/dhh_hist_timer.sv
/*
  History accumulation timer: millisecond prescaler, full interval
  update and early updates within the first interval.
  Assumes timer_ms and inc_avg are static registers of the parent.
*/
`timescale 1ns/100ps
`include "dhh_map.svh"

module dhh_hist_timer #(
  parameter int MS_CYC = `DHH_MS_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic [15:0] timer_ms,
  input wire logic [2:0] inc_avg,
  // Timing outputs
  output logic ms_tick,
  output logic update
);

  localparam int PW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;

  logic [PW-1:0] pre_q;
  logic [15:0] elapsed_q;
  logic first_q;
  logic [7:0] hit;
  logic [3:0] depth;

  // Prescaler and interval arithmetic
  wire tick_w = (pre_q == PW'(MS_CYC - 1));
  wire [15:0] next_el = elapsed_q + 16'h0001;
  // A zero timer never fires, so software must avoid it
  wire full_w = tick_w && (timer_ms != 16'h0000) &&
                (next_el == timer_ms);
  // Value 7 also reaches 1/256, one step deeper than the field
  assign depth = (inc_avg == 3'h7) ? 4'h8 : {1'b0, inc_avg};

  // One comparator per early fraction 1/2 .. 1/256
  for (genvar k = 1; k <= 8; k++)
  begin : g_early
    wire [15:0] frac = timer_ms >> k;
    assign hit[k-1] = (4'(k) <= depth) && (frac != 16'h0000) &&
                      (next_el == frac);
  end

  wire early_w = tick_w && first_q && (|hit);

  // Counters and registered pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n || restart)
    begin
      pre_q <= '0;
      elapsed_q <= 16'h0000;
      first_q <= 1'b1;
      ms_tick <= 1'b0;
      update <= 1'b0;
    end
    else
    begin
      pre_q <= tick_w ? '0 : PW'(pre_q + 1'b1);
      ms_tick <= tick_w;
      update <= full_w || early_w;
      if (full_w)
      begin
        elapsed_q <= 16'h0000;
        first_q <= 1'b0;
      end
      else if (tick_w)
        elapsed_q <= next_el;
    end
  end

endmodule // dhh_hist_timer

// ===== rtl/dhh_slew_lim.sv
/*
  Phase slew limiter: moves the applied phase toward the target by at
  most limit picoseconds per microsecond.
  Assumes target changes slowly compared with the microsecond tick.
*/
`timescale 1ns/100ps
`include "dhh_map.svh"

module dhh_slew_lim #(
  parameter int US_CYC = `DHH_US_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [31:0] target,
  input wire logic [15:0] limit,
  // Result
  output logic [31:0] phase_q,
  output logic limiting
);

  localparam int PW = (US_CYC > 1) ? $clog2(US_CYC) : 1;

  logic [PW-1:0] pre_q;
  dhh_pkg::dhh_slew_st_t st_q;

  // Distance to go, compared against one tick's allowance
  wire tick_w = (pre_q == PW'(US_CYC - 1));
  wire signed [32:0] diff_w = $signed({target[31], target}) -
                              $signed({phase_q[31], phase_q});
  wire signed [32:0] lim_w = $signed({17'h00000, limit});
  wire over_pos = diff_w > lim_w;
  wire over_neg = diff_w < -lim_w;
  wire [31:0] up_w = phase_q + {16'h0000, limit};
  wire [31:0] dn_w = phase_q - {16'h0000, limit};

  // Zero limit bypasses the limiter at once
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_q <= '0;
      phase_q <= 32'h00000000;
      st_q <= dhh_pkg::SLW_TRACK;
    end
    else if (limit == 16'h0000)
    begin
      pre_q <= '0;
      phase_q <= target;
      st_q <= dhh_pkg::SLW_TRACK;
    end
    else
    begin
      pre_q <= tick_w ? '0 : PW'(pre_q + 1'b1);
      if (tick_w)
      begin
        case (st_q)
          dhh_pkg::SLW_TRACK,
          dhh_pkg::SLW_LIMIT:
          begin
            if (over_pos || over_neg)
            begin
              phase_q <= over_pos ? up_w : dn_w;
              st_q <= dhh_pkg::SLW_LIMIT;
            end
            else
            begin
              phase_q <= target;
              st_q <= dhh_pkg::SLW_TRACK;
            end
          end
          default:
            st_q <= dhh_pkg::SLW_TRACK;
        endcase
      end
    end
  end

  assign limiting = (st_q == dhh_pkg::SLW_LIMIT);

endmodule // dhh_slew_lim

// ===== rtl/dhh_ctrl.sv
/*
  Holdover history and locked-state phase control: AXI4-Lite register
  file, tuning word averaging, holdover source choice, phase offset
  stepping with slew limiting, and the event interrupt.
  Assumes dpll_i is synchronous to clk and its strobes are one cycle.
*/
`timescale 1ns/100ps
`include "dhh_map.svh"

// Function
// - Step register sets locked static phase offset
// - Slew limit bounds phase movement rate
// - Zero slew limit disables limiting
// - Average tuning words over timer interval
// - No history: fallback bit picks source
// - Reference switch clears history unless persistent
// - Early updates only in first interval
// - History update raises maskable event
// - Slew limiter entry and exit events
// - Free run word is 30-bit register
module dhh_ctrl #(
  parameter int ADDR_W = 12,
  parameter int MS_CYC = `DHH_MS_CYC,
  parameter int US_CYC = `DHH_US_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loop core
  input wire dhh_pkg::dhh_dpll_in_t dpll_i,
  output dhh_pkg::dhh_dpll_out_t dpll_o,
  // Interrupt
  output logic irq
);

  // Parameters the logic cannot serve
  if (ADDR_W < 12)
  begin : g_chk_addr
    $error("ADDR_W must reach the status register");
  end
  if (MS_CYC < 1 || US_CYC < 1)
  begin : g_chk_cyc
    $error("Cycle counts must be at least one");
  end

  // Bus capture state
  logic aw_held_q;
  logic w_held_q;
  logic [9:0] aw_idx_q;
  logic [7:0] wd_q;
  logic wen_q;

  // Configuration registers
  logic [15:0] step_q;
  logic [15:0] slew_q;
  logic [15:0] timer_q;
  logic [4:0] mode_q;
  logic [29:0] frtw_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_st_q;

  // History and phase state
  logic [45:0] sum_q;
  logic [15:0] cnt_q;
  logic [29:0] avg_q;
  logic hist_q;
  logic [29:0] last_tw_q;
  logic [31:0] target_q;
  logic slew_prev_q;

  // Sub-block results
  logic ms_tick;
  logic upd;
  logic [31:0] phase_w;
  logic slew_lim;

  // Write decode, done once both halves are captured
  wire do_wr = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_en = do_wr && wen_q;
  wire wr_frtw0 = wr_en && (aw_idx_q == `DHH_IDX_FRTW0);
  wire wr_frtw1 = wr_en && (aw_idx_q == `DHH_IDX_FRTW1);
  wire wr_frtw2 = wr_en && (aw_idx_q == `DHH_IDX_FRTW2);
  wire wr_frtw3 = wr_en && (aw_idx_q == `DHH_IDX_FRTW3);
  wire wr_step_lo = wr_en && (aw_idx_q == `DHH_IDX_STEP_LO);
  wire wr_step_hi = wr_en && (aw_idx_q == `DHH_IDX_STEP_HI);
  wire wr_slew_lo = wr_en && (aw_idx_q == `DHH_IDX_SLEW_LO);
  wire wr_slew_hi = wr_en && (aw_idx_q == `DHH_IDX_SLEW_HI);
  wire wr_tmr_lo = wr_en && (aw_idx_q == `DHH_IDX_TIMER_LO);
  wire wr_tmr_hi = wr_en && (aw_idx_q == `DHH_IDX_TIMER_HI);
  wire wr_mode = wr_en && (aw_idx_q == `DHH_IDX_MODE);
  wire wr_ien = wr_en && (aw_idx_q == `DHH_IDX_IRQ_EN);
  wire wr_clr = wr_en && (aw_idx_q == `DHH_IDX_IRQ_CLR);
  // Status register is read-only, so a write to it is an error
  wire wr_ok = (aw_idx_q >= `DHH_IDX_FRTW0 &&
                aw_idx_q <= `DHH_IDX_FRTW3) ||
               (aw_idx_q >= `DHH_IDX_STEP_LO &&
                aw_idx_q <= `DHH_IDX_MODE) ||
               (aw_idx_q >= `DHH_IDX_IRQ_STAT &&
                aw_idx_q <= `DHH_IDX_IRQ_CLR);

  // Address handshake channel
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_held_q <= 1'b0;
      aw_idx_q <= 10'h000;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_idx_q <= s_axi_awaddr[11:2];
      s_axi_awready <= 1'b0;
    end
    else if (do_wr)
      aw_held_q <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1; // One write under way at a time
  end

  // Data handshake channel
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      w_held_q <= 1'b0;
      wd_q <= 8'h00;
      wen_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wd_q <= s_axi_wdata[7:0];
      wen_q <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else if (do_wr)
      w_held_q <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // Write response
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DHH_RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `DHH_RESP_OKAY : `DHH_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Byte-wide fields, lower index carries the low byte
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_q <= `DHH_RST_STEP;
      slew_q <= `DHH_RST_SLEW;
      timer_q <= `DHH_RST_TIMER;
    end
    else
    begin
      if (wr_step_lo) step_q[7:0] <= wd_q;
      if (wr_step_hi) step_q[15:8] <= wd_q;
      if (wr_slew_lo) slew_q[7:0] <= wd_q;
      if (wr_slew_hi) slew_q[15:8] <= wd_q;
      if (wr_tmr_lo) timer_q[7:0] <= wd_q;
      if (wr_tmr_hi) timer_q[15:8] <= wd_q;
    end
  end

  // Free run word, mode and interrupt enable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      frtw_q <= `DHH_RST_FRTW;
      mode_q <= `DHH_RST_MODE;
      irq_en_q <= 8'h00;
    end
    else
    begin
      if (wr_frtw0) frtw_q[7:0] <= wd_q;
      if (wr_frtw1) frtw_q[15:8] <= wd_q;
      if (wr_frtw2) frtw_q[23:16] <= wd_q;
      if (wr_frtw3) frtw_q[29:24] <= wd_q[5:0];
      if (wr_mode) mode_q <= wd_q[4:0];
      if (wr_ien) irq_en_q <= wd_q & `DHH_IRQ_MASK;
    end
  end

  // Read mux; unmapped and write-only indices read zero
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire rd_ok = (rd_idx >= `DHH_IDX_FRTW0 && rd_idx <= `DHH_IDX_FRTW3) ||
               (rd_idx >= `DHH_IDX_STEP_LO && rd_idx <= `DHH_IDX_MODE) ||
               (rd_idx >= `DHH_IDX_IRQ_STAT &&
                rd_idx <= `DHH_IDX_STATUS);
  wire [7:0] stat_w = {5'h00, dpll_i.holdover, slew_lim, hist_q};
  wire [7:0] rd_val =
    (rd_idx == `DHH_IDX_FRTW0) ? frtw_q[7:0] :
    (rd_idx == `DHH_IDX_FRTW1) ? frtw_q[15:8] :
    (rd_idx == `DHH_IDX_FRTW2) ? frtw_q[23:16] :
    (rd_idx == `DHH_IDX_FRTW3) ? ({2'h0, frtw_q[29:24]} &
                                  `DHH_FRTW3_MASK) :
    (rd_idx == `DHH_IDX_STEP_LO) ? step_q[7:0] :
    (rd_idx == `DHH_IDX_STEP_HI) ? step_q[15:8] :
    (rd_idx == `DHH_IDX_SLEW_LO) ? slew_q[7:0] :
    (rd_idx == `DHH_IDX_SLEW_HI) ? slew_q[15:8] :
    (rd_idx == `DHH_IDX_TIMER_LO) ? timer_q[7:0] :
    (rd_idx == `DHH_IDX_TIMER_HI) ? timer_q[15:8] :
    (rd_idx == `DHH_IDX_MODE) ? {3'h0, mode_q} :
    (rd_idx == `DHH_IDX_IRQ_STAT) ? irq_st_q :
    (rd_idx == `DHH_IDX_IRQ_EN) ? irq_en_q :
    (rd_idx == `DHH_IDX_STATUS) ? stat_w : 8'h00;

  // Read channel, answered one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DHH_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_ok ? `DHH_RESP_OKAY : `DHH_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // History is dropped on a switch only without persistence
  wire hist_clr = dpll_i.ref_switch && !mode_q[`DHH_MODE_PERSIST];

  dhh_hist_timer #(
    .MS_CYC(MS_CYC)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(hist_clr),
    .timer_ms(timer_q),
    .inc_avg(mode_q[2:0]),
    .ms_tick(ms_tick),
    .update(upd)
  );

  // One sample per millisecond keeps the sum within 46 bits
  wire hist_upd = upd && (cnt_q != 16'h0000);
  wire [45:0] quot_w = sum_q / {30'h00000000, cnt_q};

  // Tuning word accumulation and averaging
  always_ff @(posedge clk)
  begin
    if (!rst_n || hist_clr)
    begin
      sum_q <= 46'h000000000000;
      cnt_q <= 16'h0000;
      hist_q <= 1'b0;
      avg_q <= 30'h00000000;
    end
    else if (hist_upd)
    begin
      avg_q <= quot_w[29:0];
      hist_q <= 1'b1;
      sum_q <= 46'h000000000000;
      cnt_q <= 16'h0000;
    end
    else if (ms_tick && dpll_i.locked && !dpll_i.holdover)
    begin
      sum_q <= sum_q + {16'h0000, dpll_i.tw};
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Last live tuning word, frozen while in holdover
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      last_tw_q <= 30'h00000000;
    else if (dpll_i.locked && !dpll_i.holdover)
      last_tw_q <= dpll_i.tw;
  end

  // Holdover source: history, else last word or free run word
  wire [29:0] fallback_w = mode_q[`DHH_MODE_FALLBACK] ?
                           last_tw_q : frtw_q;
  wire [29:0] hold_src = hist_q ? avg_q : fallback_w;

  // Static offset moves by one step per strobe while locked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      target_q <= 32'h00000000;
    else if (dpll_i.locked && dpll_i.step_up && !dpll_i.step_dn)
      target_q <= target_q + {16'h0000, step_q};
    else if (dpll_i.locked && dpll_i.step_dn && !dpll_i.step_up)
      target_q <= target_q - {16'h0000, step_q};
  end

  dhh_slew_lim #(
    .US_CYC(US_CYC)
  ) u_slew (
    .clk(clk),
    .rst_n(rst_n),
    .target(target_q),
    .limit(slew_q),
    .phase_q(phase_w),
    .limiting(slew_lim)
  );

  // Events; a new event beats a clear in the same cycle
  logic [7:0] ev_w;
  always_comb
  begin
    ev_w = 8'h00;
    ev_w[`DHH_IRQ_HIST] = hist_upd;
    ev_w[`DHH_IRQ_SLEW_ON] = slew_lim && !slew_prev_q;
    ev_w[`DHH_IRQ_SLEW_OFF] = !slew_lim && slew_prev_q;
  end
  wire [7:0] clr_w = wr_clr ? wd_q : 8'h00;

  // Sticky status, interrupt level and loop outputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_st_q <= 8'h00;
      slew_prev_q <= 1'b0;
      irq <= 1'b0;
      dpll_o <= '0;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~clr_w) | ev_w;
      slew_prev_q <= slew_lim;
      irq <= |(irq_st_q & irq_en_q);
      if (!dpll_i.holdover)
        dpll_o.holdover_tw <= hold_src;
      dpll_o.phase_offset <= phase_w;
      dpll_o.hist_valid <= hist_q;
    end
  end

endmodule // dhh_ctrl

// ===== verification/dhh_ctrl_assertions.sv
/*
  Concurrent checks on the ports of the holdover history control block.
  Assumes the bind at the foot of this file attaches it to dhh_ctrl.
*/
`timescale 1ns/100ps
`include "dhh_map.svh"

module dhh_ctrl_assertions #(
  parameter int ADDR_W = 12,
  parameter int MS_CYC = `DHH_MS_CYC,
  parameter int US_CYC = `DHH_US_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Loop core and interrupt
  input wire dhh_pkg::dhh_dpll_in_t dpll_i,
  input wire dhh_pkg::dhh_dpll_out_t dpll_o,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Handshake steps of a bus transfer
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid
    && !s_axi_arready) else $error("read answer late");
  a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write ready while busy");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while busy");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside
    {`DHH_RESP_OKAY, `DHH_RESP_SLVERR}) else $error("bad write response");
  a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !s_axi_bvalid
    && !s_axi_rvalid && dpll_o == '0) else $error("outputs not reset");
  a_holdover_frozen: assert property (dpll_i.holdover
    && $past(dpll_i.holdover) |-> $stable(dpll_o.holdover_tw))
    else $error("holdover word moved");
endmodule // dhh_ctrl_assertions

bind dhh_ctrl dhh_ctrl_assertions #(.ADDR_W(ADDR_W), .MS_CYC(MS_CYC),
  .US_CYC(US_CYC)) i_chk (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .dpll_i(dpll_i), .dpll_o(dpll_o), .irq(irq));

// ===== verification/dhh_ctrl_bench.sv
/*
  Self-checking bench for the holdover history control block.
  Assumes shortened millisecond and microsecond counts in the instance.
*/
`timescale 1ns/100ps
`include "dhh_map.svh"
`define CHK(nm, e, a) begin num_checks++; if ((e) !== (a)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end

module dhh_ctrl_bench;
  logic clk, rst_n, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bexp;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  dhh_pkg::dhh_dpll_in_t dpll_i;
  dhh_pkg::dhh_dpll_out_t dpll_o;
  int n_errors, num_checks, n;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] rexp;
  logic [29:0] tw_a, tw_b;
  logic [7:0] v;
  logic [9:0] ri [12] = '{`DHH_IDX_STEP_LO, `DHH_IDX_STEP_HI,
    `DHH_IDX_SLEW_LO, `DHH_IDX_SLEW_HI, `DHH_IDX_TIMER_LO, `DHH_IDX_TIMER_HI,
    `DHH_IDX_MODE, `DHH_IDX_FRTW3, `DHH_IDX_FRTW0, `DHH_IDX_FRTW1,
    `DHH_IDX_FRTW2, `DHH_IDX_IRQ_EN};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h00, 8'h00,
    8'h1b, 8'h11, 8'h15, 8'h64, 8'h00};

  dhh_ctrl #(.ADDR_W(12), .MS_CYC(20), .US_CYC(2)) i_dut (.clk(clk),
    .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .dpll_i(dpll_i), .dpll_o(dpll_o), .irq(irq));

  // 20 MHz clock
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // Oldest note against each bus answer
  always @(posedge clk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      bexp = bq.pop_front();
      `CHK("bresp", bexp, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rexp = rq.pop_front();
      `CHK("rdata", rexp, {s_axi_rresp, s_axi_rdata})
    end
  end

  // Ready raised late so the slave must hold its answer
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
      input logic [1:0] r = `DHH_RESP_OKAY);
    logic ad, wd;
    bq.push_back(r);
    ad = 0;
    wd = 0;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (s_axi_awready)
      begin
        s_axi_awvalid <= 0;
        ad = 1;
      end
      if (s_axi_wready)
      begin
        s_axi_wvalid <= 0;
        wd = 1;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1;
    @(posedge clk);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [9:0] i, input logic [7:0] d,
      input logic [1:0] r = `DHH_RESP_OKAY);
    rq.push_back({r, 24'h0, d});
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1;
    @(posedge clk);
    s_axi_rready <= 0;
  endtask

  // One-cycle strobes: reference switch, step up, step down
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    {dpll_i.ref_switch, dpll_i.step_up, dpll_i.step_dn} <= p;
    @(posedge clk);
    {dpll_i.ref_switch, dpll_i.step_up, dpll_i.step_dn} <= 3'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (8000) @(posedge clk);
    n_errors++;
    conclude;
  end

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'h1;
    dpll_i = '0;
    dpll_i.locked = 1;
    dpll_i.holdover = 1;
    rst_n = 0;
    void'($urandom(59));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    for (int k = 0; k < 12; k++)
      rd(ri[k], rv[k]);
    rd(10'h3ff, 8'h00, `DHH_RESP_SLVERR);
    wr(10'h3ff, 8'h5a, `DHH_RESP_SLVERR);
    wr(`DHH_IDX_STATUS, 8'h01, `DHH_RESP_SLVERR);
    $display("test reset values done");
    // Low bit forced so the timer never holds zero
    for (int k = 0; k < 8; k++)
    begin
      v = $urandom | 8'h01;
      wr(ri[k], v);
      rd(ri[k], k == 6 ? v & 8'h1f : k == 7 ? v & 8'h3f : v);
    end
    $display("test read back done");
    wr(`DHH_IDX_SLEW_LO, 8'h00);
    wr(`DHH_IDX_SLEW_HI, 8'h00);
    wr(`DHH_IDX_STEP_LO, 8'h23);
    wr(`DHH_IDX_STEP_HI, 8'h01);
    pulse(3'h2);
    `CHK("offset", dpll_o.phase_offset, 32'h00000123)
    pulse(3'h3);
    `CHK("offset", dpll_o.phase_offset, 32'h00000123)
    pulse(3'h1);
    `CHK("offset", dpll_o.phase_offset, 32'h00000000)
    wr(`DHH_IDX_STEP_LO, 8'h40);
    wr(`DHH_IDX_STEP_HI, 8'h00);
    wr(`DHH_IDX_SLEW_LO, 8'h03);
    pulse(3'h2);
    `CHK("slew", dpll_o.phase_offset inside {[1:18]}, 1'b1)
    rd(`DHH_IDX_IRQ_STAT, 8'h01);
    rd(`DHH_IDX_STATUS, 8'h06);
    repeat (60) @(posedge clk);
    `CHK("offset", dpll_o.phase_offset, 32'h00000040)
    rd(`DHH_IDX_IRQ_STAT, 8'h03);
    `CHK("irq", irq, 1'b0)
    wr(`DHH_IDX_IRQ_EN, 8'h13);
    repeat (2) @(posedge clk);
    `CHK("irq", irq, 1'b1)
    wr(`DHH_IDX_IRQ_CLR, 8'h03);
    repeat (2) @(posedge clk);
    `CHK("irq", irq, 1'b0)
    rd(`DHH_IDX_IRQ_STAT, 8'h00);
    $display("test phase step done");
    wr(`DHH_IDX_TIMER_LO, 8'h04);
    wr(`DHH_IDX_TIMER_HI, 8'h00);
    wr(`DHH_IDX_MODE, 8'h02);
    tw_a = $urandom;
    tw_b = $urandom;
    dpll_i.tw <= tw_a;
    dpll_i.holdover <= 0;
    pulse(3'h4);
    `CHK("valid", dpll_o.hist_valid, 1'b0)
    // Top byte of the free run word was rewritten with v in the loop above
    `CHK("hold_tw", dpll_o.holdover_tw, {v[5:0], 24'h641511})
    n = 0;
    while (dpll_o.hist_valid !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    // Quarter point has no sample yet, so the half point (2 ms) counts
    `CHK("early", n inside {[35:45]}, 1'b1)
    repeat (2) @(posedge clk);
    `CHK("hold_tw", dpll_o.holdover_tw, tw_a)
    `CHK("irq", irq, 1'b1)
    rd(`DHH_IDX_IRQ_STAT, 8'h10);
    wr(`DHH_IDX_MODE, 8'h0a);
    pulse(3'h4);
    `CHK("valid", dpll_o.hist_valid, 1'b1)
    wr(`DHH_IDX_MODE, 8'h12);
    dpll_i.tw <= tw_b;
    pulse(3'h4);
    `CHK("valid", dpll_o.hist_valid, 1'b0)
    `CHK("hold_tw", dpll_o.holdover_tw, tw_b)
    dpll_i.holdover <= 1;
    dpll_i.tw <= tw_a;
    repeat (4) @(posedge clk);
    `CHK("hold_tw", dpll_o.holdover_tw, tw_b)
    $display("test history done");
    conclude;
  end
endmodule // dhh_ctrl_bench
